// >>> hdl/cgc_top.sv
// module: clock generator control block with AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module cgc_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slow_clock,
    input wire logic main_clock,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] periph_clk_en,
    output logic osc_enable,
    output logic osc_bypass,
    output logic [7:0] pll1_divider,
    output logic [10:0] pll1_multiplier,
    output logic pll1_active,
    output logic [7:0] pll2_divider,
    output logic [10:0] pll2_multiplier,
    output logic pll2_active,
    output logic [2:0] usb_div_factor,
    output logic [1:0] clock_source_select,
    output logic [6:0] processor_div_factor,
    output logic [2:0] master_div_factor
);
    // =========================================================
    // state
    // =========================================================
    typedef enum logic [2:0] {
        CGC_OSC_OFF = 3'b001,
        CGC_OSC_WAIT = 3'b010,
        CGC_OSC_STABLE = 3'b100
    } cgc_osc_t;

    typedef struct packed {
        logic [31:0] gate;
        logic [31:0] osc_ctrl;
        logic [31:0] pll1;
        logic [31:0] pll2;
        logic [31:0] mck;
        cgc_osc_t osc;
        logic [10:0] osc_cnt;
        logic [1:0] slow_sync;
        logic slow_prev;
        logic [1:0] main_sync;
        logic main_prev;
        logic [4:0] meas_per;
        logic [15:0] meas_acc;
        logic [15:0] meas_val;
        logic meas_valid;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] pll_start;
    } cgc_state_t;

    cgc_state_t st_r;
    cgc_state_t st_nxt;

    cgc_pll_if pll1_if ();
    cgc_pll_if pll2_if ();

    // =========================================================
    // helpers
    // =========================================================
    function automatic logic [31:0] cgc_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction : cgc_merge

    // 2-bit code to divide factor 1, 2, 4; reserved code reads as 0 (no output)
    function automatic logic [2:0] cgc_div124(input logic [1:0] code);
        case (code)
            2'h0: return 3'h1;
            2'h1: return 3'h2;
            2'h2: return 3'h4;
            default: return 3'h0;
        endcase
    endfunction : cgc_div124

    logic slow_tick;
    logic main_tick;
    logic osc_on;
    logic [3:0] status_bits;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic wr_hit;

    assign slow_tick = st_r.slow_sync[1] & ~st_r.slow_prev;
    assign main_tick = st_r.main_sync[1] & ~st_r.main_prev;
    assign osc_on = st_r.osc_ctrl[cgc_pkg::OSC_EN_BIT] | st_r.osc_ctrl[cgc_pkg::OSC_BYP_BIT];

    always_comb begin
        status_bits = '0;
        status_bits[cgc_pkg::ST_OSC] = (st_r.osc == CGC_OSC_STABLE);
        status_bits[cgc_pkg::ST_LOCK1] = pll1_if.locked;
        status_bits[cgc_pkg::ST_LOCK2] = pll2_if.locked;
        // master clock ready is fixed high: switching is instantaneous in this model
        status_bits[cgc_pkg::ST_MASTER_CLOCK_READY] = 1'b1;
    end

    // =========================================================
    // read decode
    // =========================================================
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr[7:0])
            cgc_pkg::OFF_GATE_STATE: rd_mux = st_r.gate;
            cgc_pkg::OFF_OSC_CTRL: rd_mux = st_r.osc_ctrl;
            cgc_pkg::OFF_MEASURE: begin
                rd_mux[15:0] = st_r.meas_val;
                rd_mux[cgc_pkg::MEAS_VALID_BIT] = st_r.meas_valid & osc_on;
            end
            cgc_pkg::OFF_PLL1: rd_mux = st_r.pll1;
            cgc_pkg::OFF_PLL2: rd_mux = st_r.pll2;
            cgc_pkg::OFF_MCK_SEL: rd_mux = st_r.mck;
            cgc_pkg::OFF_STATUS: rd_mux[3:0] = status_bits;
            cgc_pkg::OFF_GATE_ON, cgc_pkg::OFF_GATE_OFF: rd_mux = 32'h0000_0000;
            default: rd_hit = 1'b0;
        endcase
        if (s_axi_araddr[31:8] != 24'h00_0000) begin
            rd_hit = 1'b0;
        end
    end

    always_comb begin
        case (st_r.aw_addr)
            cgc_pkg::OFF_GATE_ON, cgc_pkg::OFF_GATE_OFF, cgc_pkg::OFF_OSC_CTRL,
            cgc_pkg::OFF_PLL1, cgc_pkg::OFF_PLL2, cgc_pkg::OFF_MCK_SEL: wr_hit = 1'b1;
            cgc_pkg::OFF_GATE_STATE, cgc_pkg::OFF_MEASURE, cgc_pkg::OFF_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // bus handshake: address and data are latched independently, then answered
    assign s_axi_awready = ~st_r.aw_hold & ~st_r.bvalid;
    assign s_axi_wready = ~st_r.w_hold & ~st_r.bvalid;
    assign s_axi_arready = ~st_r.rvalid;

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        logic [31:0] wd;
        wd = '0;
        st_nxt = st_r;
        st_nxt.pll_start = 2'h0;

        // first flop feeds only the second
        st_nxt.slow_sync = {st_r.slow_sync[0], slow_clock};
        st_nxt.slow_prev = st_r.slow_sync[1];
        st_nxt.main_sync = {st_r.main_sync[0], main_clock};
        st_nxt.main_prev = st_r.main_sync[1];

        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_hold = 1'b1;
            st_nxt.aw_addr = (s_axi_awaddr[31:8] == 24'h00_0000) ? s_axi_awaddr[7:0] : 8'hFF;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_hold = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        if (st_r.aw_hold && st_r.w_hold) begin
            st_nxt.aw_hold = 1'b0;
            st_nxt.w_hold = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_hit ? cgc_pkg::RESP_OKAY : cgc_pkg::RESP_SLVERR;
            wd = cgc_merge(32'h0000_0000, st_r.w_data, st_r.w_strb, cgc_pkg::MASK_GATE);
            case (st_r.aw_addr)
                cgc_pkg::OFF_GATE_ON: st_nxt.gate = st_r.gate | wd;
                cgc_pkg::OFF_GATE_OFF: st_nxt.gate = st_r.gate & ~wd;
                cgc_pkg::OFF_OSC_CTRL: st_nxt.osc_ctrl = cgc_merge(st_r.osc_ctrl, st_r.w_data,
                    st_r.w_strb, cgc_pkg::MASK_OSC_CTRL);
                cgc_pkg::OFF_PLL1: begin
                    st_nxt.pll1 = cgc_merge(st_r.pll1, st_r.w_data, st_r.w_strb,
                        cgc_pkg::MASK_PLL1);
                    st_nxt.pll_start[0] = 1'b1;
                end
                cgc_pkg::OFF_PLL2: begin
                    st_nxt.pll2 = cgc_merge(st_r.pll2, st_r.w_data, st_r.w_strb,
                        cgc_pkg::MASK_PLL2);
                    st_nxt.pll_start[1] = 1'b1;
                end
                cgc_pkg::OFF_MCK_SEL: st_nxt.mck = cgc_merge(st_r.mck, st_r.w_data,
                    st_r.w_strb, cgc_pkg::MASK_MCK_SEL);
                default: st_nxt.gate = st_r.gate;
            endcase
        end

        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_hit ? rd_mux : 32'h0000_0000;
            st_nxt.rresp = rd_hit ? cgc_pkg::RESP_OKAY : cgc_pkg::RESP_SLVERR;
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // oscillator start-up; enable and bypass are assumed exclusive
        case (st_r.osc)
            CGC_OSC_OFF: begin
                if (st_r.osc_ctrl[cgc_pkg::OSC_BYP_BIT]) begin
                    st_nxt.osc = CGC_OSC_STABLE;
                end else if (st_r.osc_ctrl[cgc_pkg::OSC_EN_BIT]) begin
                    st_nxt.osc = CGC_OSC_WAIT;
                    st_nxt.osc_cnt = {st_r.osc_ctrl[cgc_pkg::OSC_CNT_LSB +: 8], 3'h0};
                end
            end
            CGC_OSC_WAIT: begin
                if (st_r.osc_ctrl[cgc_pkg::OSC_BYP_BIT]) begin
                    st_nxt.osc = CGC_OSC_STABLE;
                end else if (!st_r.osc_ctrl[cgc_pkg::OSC_EN_BIT]) begin
                    st_nxt.osc = CGC_OSC_OFF;
                end else if (st_r.osc_cnt == 11'h000) begin
                    st_nxt.osc = CGC_OSC_STABLE;
                end else if (slow_tick) begin
                    st_nxt.osc_cnt = st_r.osc_cnt - 11'h001;
                end
            end
            CGC_OSC_STABLE: begin
                if (!osc_on) begin
                    st_nxt.osc = CGC_OSC_OFF;
                end
            end
            default: st_nxt.osc = CGC_OSC_OFF;
        endcase

        // frequency measurement over a window of slow periods
        if (!osc_on) begin
            st_nxt.meas_valid = 1'b0;
            st_nxt.meas_per = 5'h00;
            st_nxt.meas_acc = 16'h0000;
        end else begin
            if (main_tick && st_r.meas_per != 5'h00) begin
                st_nxt.meas_acc = st_r.meas_acc + 16'h0001;
            end
            if (slow_tick) begin
                if (st_r.meas_per == cgc_pkg::MEAS_PERIODS) begin
                    st_nxt.meas_val = st_r.meas_acc;
                    st_nxt.meas_valid = 1'b1;
                    st_nxt.meas_per = 5'h00;
                    st_nxt.meas_acc = 16'h0000;
                end else if (!st_r.meas_valid) begin
                    st_nxt.meas_per = st_r.meas_per + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
            st_r.gate <= cgc_pkg::RST_GATE;
            st_r.osc_ctrl <= cgc_pkg::RST_OSC_CTRL;
            st_r.pll1 <= cgc_pkg::RST_PLL;
            st_r.pll2 <= cgc_pkg::RST_PLL;
            st_r.mck <= cgc_pkg::RST_MCK_SEL;
            st_r.osc <= CGC_OSC_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =========================================================
    // pll lock counters
    // =========================================================
    assign pll1_if.start = st_r.pll_start[0];
    assign pll1_if.count = st_r.pll1[cgc_pkg::PLL_CNT_LSB +: 6];
    assign pll1_if.slow_tick = slow_tick;
    assign pll2_if.start = st_r.pll_start[1];
    assign pll2_if.count = st_r.pll2[cgc_pkg::PLL_CNT_LSB +: 6];
    assign pll2_if.slow_tick = slow_tick;

    cgc_pll_lock u_lock1 (.clk_sys(clk_sys), .rst(rst), .pif(pll1_if.lock));
    cgc_pll_lock u_lock2 (.clk_sys(clk_sys), .rst(rst), .pif(pll2_if.lock));

    // =========================================================
    // outputs; range fields are stored as written, of bits 31:27 pll1 keeps bit 29 and pll2 bits 29:28
    // =========================================================
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign periph_clk_en = st_r.gate;
    assign osc_enable = st_r.osc_ctrl[cgc_pkg::OSC_EN_BIT];
    assign osc_bypass = st_r.osc_ctrl[cgc_pkg::OSC_BYP_BIT];
    // divider 0 means no output, 1 bypass, otherwise the value itself
    assign pll1_divider = st_r.pll1[cgc_pkg::PLL_DIV_LSB +: 8];
    assign pll1_multiplier = st_r.pll1[cgc_pkg::PLL_MUL_LSB +: 11];
    assign pll1_active = (st_r.pll1[cgc_pkg::PLL_MUL_LSB +: 11] != 11'h000);
    assign pll2_divider = st_r.pll2[cgc_pkg::PLL_DIV_LSB +: 8];
    assign pll2_multiplier = st_r.pll2[cgc_pkg::PLL_MUL_LSB +: 11];
    assign pll2_active = (st_r.pll2[cgc_pkg::PLL_MUL_LSB +: 11] != 11'h000);
    assign usb_div_factor = cgc_div124(st_r.pll2[cgc_pkg::PLL_USB_LSB +: 2]);
    assign clock_source_select = st_r.mck[1:0];
    // prescaler 111 is reserved and yields 0
    assign processor_div_factor = (st_r.mck[4:2] == 3'h7) ? 7'h00
                                : 7'(7'h01 << st_r.mck[4:2]);
    assign master_div_factor = cgc_div124(st_r.mck[9:8]);
endmodule : cgc_top
`default_nettype wire

// >>> hdl/cgc_pkg.sv
// package: register map, field layout and constants of the clock generator control block
package cgc_pkg;
    // byte offsets on the register bus
    localparam logic [7:0] OFF_GATE_ON = 8'h10;
    localparam logic [7:0] OFF_GATE_OFF = 8'h14;
    localparam logic [7:0] OFF_GATE_STATE = 8'h18;
    localparam logic [7:0] OFF_OSC_CTRL = 8'h20;
    localparam logic [7:0] OFF_MEASURE = 8'h24;
    localparam logic [7:0] OFF_PLL1 = 8'h28;
    localparam logic [7:0] OFF_PLL2 = 8'h2C;
    localparam logic [7:0] OFF_MCK_SEL = 8'h30;
    localparam logic [7:0] OFF_STATUS = 8'h68;
    // reset values
    localparam logic [31:0] RST_OSC_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_PLL = 32'h0000_3F00;
    localparam logic [31:0] RST_MCK_SEL = 32'h0000_0000;
    localparam logic [31:0] RST_GATE = 32'h0000_0000;
    // writable bit masks (unused positions read zero)
    localparam logic [31:0] MASK_GATE = 32'hFFFF_FFFC;
    localparam logic [31:0] MASK_OSC_CTRL = 32'h0000_FF03;
    localparam logic [31:0] MASK_PLL1 = 32'h27FF_FFFF;
    localparam logic [31:0] MASK_PLL2 = 32'h37FF_FFFF;
    localparam logic [31:0] MASK_MCK_SEL = 32'h0000_031F;
    // field positions
    localparam int OSC_EN_BIT = 0;
    localparam int OSC_BYP_BIT = 1;
    localparam int OSC_CNT_LSB = 8;
    localparam int PLL_DIV_LSB = 0;
    localparam int PLL_CNT_LSB = 8;
    localparam int PLL_MUL_LSB = 16;
    localparam int PLL_USB_LSB = 28;
    localparam int MEAS_VALID_BIT = 16;
    localparam int ST_OSC = 0;
    localparam int ST_LOCK1 = 1;
    localparam int ST_LOCK2 = 2;
    localparam int ST_MASTER_CLOCK_READY = 3;
    // measurement window length and start-up scale in slow-clock periods
    localparam logic [4:0] MEAS_PERIODS = 5'h10;
    localparam int OSC_SCALE_SHIFT = 3;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cgc_pkg

// >>> hdl/cgc_pll_if.sv
// interface: one pll lock counter request and state
`timescale 1ns/100ps
`default_nettype none
interface cgc_pll_if;
    logic start;
    logic [5:0] count;
    logic slow_tick;
    logic locked;
    modport ctl (output start, output count, output slow_tick, input locked);
    modport lock (input start, input count, input slow_tick, output locked);
endinterface : cgc_pll_if
`default_nettype wire

// >>> hdl/cgc_pll_lock.sv
// module: slow-clock lock counter for one pll
`timescale 1ns/100ps
`default_nettype none
module cgc_pll_lock (
    input wire logic clk_sys,
    input wire logic rst,
    cgc_pll_if.lock pif
);
    typedef struct packed {
        logic [5:0] cnt;
        logic busy;
        logic locked;
    } cgc_lock_t;

    cgc_lock_t st_r;
    cgc_lock_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (pif.start) begin
            // a new write restarts the wait and drops lock
            st_nxt.cnt = pif.count;
            st_nxt.busy = 1'b1;
            st_nxt.locked = 1'b0;
        end else if (st_r.busy) begin
            if (st_r.cnt == 6'h00) begin
                st_nxt.busy = 1'b0;
                st_nxt.locked = 1'b1;
            end else if (pif.slow_tick) begin
                st_nxt.cnt = st_r.cnt - 6'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pif.locked = st_r.locked;
endmodule : cgc_pll_lock
`default_nettype wire

// >>> dv/cgc_checker.sv
// checker: port-level assertions for the clock generator control block
`timescale 1ns/100ps
`default_nettype none
module cgc_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] periph_clk_en,
    input wire logic osc_enable,
    input wire logic osc_bypass,
    input wire logic [10:0] pll1_multiplier,
    input wire logic pll1_active,
    input wire logic [10:0] pll2_multiplier,
    input wire logic pll2_active,
    input wire logic [2:0] usb_div_factor,
    input wire logic [6:0] processor_div_factor,
    input wire logic [2:0] master_div_factor
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ======================================
    // outputs against their register fields
    gate_low_a: assert property (periph_clk_en[1:0] == 2'h0)
        else $error("unused gate bits set");
    pll1_act_a: assert property (pll1_active == (pll1_multiplier != 11'h0))
        else $error("first pll active wrong");
    pll2_act_a: assert property (pll2_active == (pll2_multiplier != 11'h0))
        else $error("second pll active wrong");
    usb_code_a: assert property (usb_div_factor inside {3'h0, 3'h1, 3'h2, 3'h4})
        else $error("usb factor illegal");
    processor_prescaler_pow_a: assert property ($onehot0(processor_div_factor))
        else $error("prescaler not a power of two");
    master_clock_division_code_a: assert property (master_div_factor inside {3'h0, 3'h1, 3'h2, 3'h4})
        else $error("master factor illegal");
    // ======================================
    // bus timing
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
    busy_stall_a: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        and (s_axi_rvalid |-> !s_axi_arready))
        else $error("request taken while answer pending");
    // reset must clear outputs even while it is still asserted
    reset_clr_a: assert property (disable iff (1'b0)
        rst |=> periph_clk_en == 32'h0 && !osc_enable && !osc_bypass)
        else $error("reset did not clear outputs");
endmodule : cgc_checker
bind cgc_top cgc_checker i_chk (.*);
`default_nettype wire

// >>> dv/tb_clock_generator_control.sv
// testbench: register-level tests of the clock generator control block
`timescale 1ns/100ps
`default_nettype none
module tb_clock_generator_control;
    logic clk_sys = 1'b0, rst = 1'b1, slow_clock = 1'b0, main_clock = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, clock_source_select;
    logic [31:0] periph_clk_en, rd_d, v;
    logic osc_enable, osc_bypass, pll1_active, pll2_active;
    logic [7:0] pll1_divider, pll2_divider;
    logic [10:0] pll1_multiplier, pll2_multiplier;
    logic [2:0] usb_div_factor, master_div_factor;
    logic [6:0] processor_div_factor;
    logic [23:0] hi = 24'h0;
    logic [2:0] f4 [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    int mismatches = 0, cmp_count = 0, cyc = 0;

    cgc_top i_dut (.*);

    always #2.5 clk_sys = ~clk_sys;
    // ==================================
    // slow clock 200 ns, main clock 40 ns, watchdog
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc % 20 == 19) slow_clock <= ~slow_clock;
        if (cyc % 4 == 3) main_clock <= ~main_clock;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    // ==================================
    // bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_d;
        logic w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= {hi, a};
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge clk_sys);
            aw_d = aw_d | s_axi_awready;
            w_d = w_d | s_axi_wready;
            s_axi_awvalid <= !aw_d;
            s_axi_wvalid <= !w_d;
        end
        while (!s_axi_bvalid) @(posedge clk_sys);
        rsp = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= {hi, a};
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rd(a);
        chk(rd_d & m, e);
    endtask : rc
    task automatic complete_run();
        if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    // ==================================
    // tests
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rc(cgc_pkg::OFF_OSC_CTRL, cgc_pkg::RST_OSC_CTRL, '1);
        rc(cgc_pkg::OFF_PLL1, cgc_pkg::RST_PLL, '1);
        rc(cgc_pkg::OFF_PLL2, cgc_pkg::RST_PLL, '1);
        rc(cgc_pkg::OFF_MCK_SEL, cgc_pkg::RST_MCK_SEL, '1);
        rc(cgc_pkg::OFF_GATE_STATE, cgc_pkg::RST_GATE, '1);
        rc(cgc_pkg::OFF_MEASURE, 32'h0, '1);
        rc(cgc_pkg::OFF_STATUS, 32'h8, 32'h9);
        wr(cgc_pkg::OFF_GATE_ON, 32'hFFFF_FFFF, 4'hF);
        rc(cgc_pkg::OFF_GATE_STATE, 32'hFFFF_FFFC, '1);
        chk(periph_clk_en, 32'hFFFF_FFFC);
        wr(cgc_pkg::OFF_GATE_OFF, 32'h8000_0005, 4'hF);
        // lane 1 not strobed, so peripherals 8..15 must keep running
        wr(cgc_pkg::OFF_GATE_OFF, 32'h0000_FF00, 4'h1);
        rc(cgc_pkg::OFF_GATE_STATE, 32'h7FFF_FFF8, '1);
        chk(periph_clk_en, 32'h7FFF_FFF8);
        rc(cgc_pkg::OFF_GATE_OFF, 32'h0, '1);
        wr(cgc_pkg::OFF_PLL1, 32'h2005_0203, 4'hF);
        rc(cgc_pkg::OFF_STATUS, 32'h0, 32'h2);
        chk({24'h0, pll1_divider}, 32'h3);
        chk({21'h0, pll1_multiplier}, 32'h5);
        repeat (160) @(posedge clk_sys);
        rc(cgc_pkg::OFF_STATUS, 32'h2, 32'h2);
        rc(cgc_pkg::OFF_PLL1, 32'h2005_0203, '1);
        wr(cgc_pkg::OFF_PLL1, 32'h2000_0001, 4'hF);
        chk({23'h0, pll1_divider, pll1_active}, 32'h2);
        for (int u = 0; u < 4; u++) begin
            v = 32'h8007_0104 | (u << 28);
            wr(cgc_pkg::OFF_PLL2, v, 4'hF);
            chk({29'h0, usb_div_factor}, {29'h0, f4[u]});
        end
        // divider in 31:24, multiplier in 21:11, active flag in bit 0
        chk({pll2_divider, 2'h0, pll2_multiplier, 10'h0, pll2_active},
            32'h0400_3801);
        repeat (120) @(posedge clk_sys);
        rc(cgc_pkg::OFF_STATUS, 32'h4, 32'h4);
        rc(cgc_pkg::OFF_PLL2, 32'h3007_0104, '1);
        for (int i = 0; i < 8; i++) begin
            // bit 31 is unused and must read back as zero
            v = {1'b1, 21'h0, 2'(i), 3'h0, 3'(i), 2'(i)};
            wr(cgc_pkg::OFF_MCK_SEL, v, 4'hF);
            rc(cgc_pkg::OFF_MCK_SEL, v & cgc_pkg::MASK_MCK_SEL, '1);
            chk({30'h0, clock_source_select}, 32'(i % 4));
            chk({25'h0, processor_div_factor}, (i == 7) ? 32'h0 : 32'h1 << i);
            chk({29'h0, master_div_factor}, {29'h0, f4[i % 4]});
        end
        wr(cgc_pkg::OFF_OSC_CTRL, 32'h0000_0201, 4'hF);
        rc(cgc_pkg::OFF_STATUS, 32'h0, 32'h1);
        repeat (560) @(posedge clk_sys);
        rc(cgc_pkg::OFF_STATUS, 32'h0, 32'h1);
        repeat (200) @(posedge clk_sys);
        rc(cgc_pkg::OFF_STATUS, 32'h1, 32'h1);
        repeat (1000) @(posedge clk_sys);
        rd(cgc_pkg::OFF_MEASURE);
        chk({31'h0, rd_d[16]}, 32'h1);
        chk({31'h0, rd_d[15:0] inside {[16'h004F:16'h0051]}}, 32'h1);
        wr(cgc_pkg::OFF_OSC_CTRL, 32'h0, 4'hF);
        rc(cgc_pkg::OFF_STATUS, 32'h0, 32'h1);
        rc(cgc_pkg::OFF_MEASURE, 32'h0, 32'h1_0000);
        wr(cgc_pkg::OFF_OSC_CTRL, 32'h2, 4'hF);
        repeat (2) @(posedge clk_sys);
        rc(cgc_pkg::OFF_STATUS, 32'h1, 32'h1);
        chk({30'h0, osc_bypass, osc_enable}, 32'h2);
        rd(8'h34);
        chk({rd_d[29:0], rsp}, {30'h0, cgc_pkg::RESP_SLVERR});
        hi = 24'h1;
        wr(cgc_pkg::OFF_MCK_SEL, 32'h0, 4'hF);
        chk({30'h0, rsp}, {30'h0, cgc_pkg::RESP_SLVERR});
        hi = 24'h0;
        rc(cgc_pkg::OFF_MCK_SEL, v & cgc_pkg::MASK_MCK_SEL, '1);
        complete_run();
    end
endmodule : tb_clock_generator_control
`default_nettype wire
